// file: bench/swc_sink_model.sv
// downstream sink model for the stereo width block
`timescale 1ns/1ps
module swc_sink_model (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic slow_i,
  output logic      m_ready_o
);
  logic [5:0] cnt_q;
  // slow mode takes one word in 64 cycles, so the buffer fills
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  assign m_ready_o = !slow_i || (cnt_q == 6'h3F);
endmodule

// file: bench/test_swc_stereo_width.sv
// self-checking bench for the stereo width block
`timescale 1ns/1ps
module test_swc_stereo_width;
  import swc_pkg::*;
  logic clk_i = 0, nrst_i = 0, psel = 0, pen = 0, pwr = 0, sv = 0, slow = 0, ce = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwd = '0, seed = 32'd53, prd, rd;
  logic [SW-1:0] sl = '0, sr = '0, ml, mr;
  logic pready, perr, srdy, mv, mrdy, er;
  logic [3:0] on = 4'hF;  // left, right, center, side gains on
  int bad_count = 0, comparisons = 0, cyc = 0, skew = 0;
  int hl[$], hr[$], el[$], eq[$];
  logic [11:0] ra [4] = '{ADDR_GAIN_IN, ADDR_GAIN_MID, ADDR_SHELF, ADDR_METER};
  logic [31:0] rv [4] = '{32'h00009E9E, 32'h00009E9E, 32'h00C8009E, 32'h000003E8};
  logic [3:0] mo [7] = '{4'hF, 4'hE, 4'hD, 4'hB, 4'h7, 4'hF, 4'hF};
  int ms [7] = '{0, 0, 0, 0, 0, 3, -4};

  swc_stereo_width DUT (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .pready_o(pready),
    .prdata_o(prd), .pslverr_o(perr), .s_valid_i(sv), .s_ready_o(srdy), .s_left_i(sl),
    .s_right_i(sr), .m_valid_o(mv), .m_ready_i(mrdy), .m_left_o(ml), .m_right_o(mr));
  swc_sink_model sink (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow), .m_ready_o(mrdy));

  initial forever #5 clk_i = ~clk_i;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] gc(logic b);
    return b ? GAIN_0DB : GAIN_OFF;
  endfunction
  function automatic int sat(int v);
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // rounding of halves and gain table drift allowed two steps
  task automatic near(string nm, int seen, int exp);
    check(nm, 32'((seen > exp + 2 || seen < exp - 2) ? seen : exp), 32'(exp));
  endtask
  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk_i);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask
  // expected output worked out at the accept edge, from the settings then
  task automatic send(int l, int r);
    int a, b, c, s, k;
    @(posedge clk_i);
    sv <= 1;
    sl <= SW'(l);
    sr <= SW'(r);
    do @(posedge clk_i); while (srdy !== 1'b1);
    sv <= 0;
    hl.push_back(l);
    hr.push_back(r);
    k = hl.size() - 1;
    a = !on[0] ? 0 : (skew <= 0 ? l : (k >= skew ? hl[k - skew] : 0));
    b = !on[1] ? 0 : (skew >= 0 ? r : (k >= -skew ? hr[k + skew] : 0));
    c = on[2] ? (a + b) / 2 : 0;
    s = on[3] ? (a - b) / 2 : 0;
    el.push_back(sat(c + s));
    eq.push_back(sat(c - s));
  endtask
  task automatic corr(int p, logic [3:0] g, logic [6:0] exp);
    on = g;
    apb(1, ADDR_GAIN_IN, {16'h0, gc(g[1]), gc(g[0])});
    repeat (300) begin
      seed = xs(seed);
      send(int'($signed(seed[13:0])), p * int'($signed(seed[13:0])));
    end
    while (el.size() > 0) @(posedge clk_i);
    apb(0, ADDR_STATUS, 0);
    near("correlation", int'(rd[6:0]), int'(exp));
  endtask

  // ****************************************************************
  // output monitor and timeout
  // ****************************************************************
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    // brief freeze now and then, so the enable path is exercised
    ce <= (cyc % 53) != 7;
    if (mv === 1'b1 && mrdy === 1'b1 && ce === 1'b1) begin
      check("output present", 32'(el.size() > 0), 32'h1);
      if (el.size() > 0) begin
        near("left out", int'($signed(ml)), el.pop_front());
        near("right out", int'($signed(mr)), eq.pop_front());
      end
    end
    if (cyc == 60000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1;
    for (int i = 0; i < 4; i++) begin
      apb(0, ra[i], 0);
      check("reset value", rd, rv[i]);
    end
    apb(1, 12'h018, 32'h1);
    check("unmapped error", {31'h0, er}, 32'h1);
    // each gain path off in turn, then both skews, last with a stalling sink
    for (int m = 0; m < 7; m++) begin
      on = mo[m];
      skew = ms[m];
      slow <= (m == 6);
      apb(1, ADDR_GAIN_IN, {16'h0, gc(on[1]), gc(on[0])});
      apb(1, ADDR_GAIN_MID, {16'h0, gc(on[3]), gc(on[2])});
      apb(1, ADDR_SKEW, 32'(skew) & 32'h3FF);
      repeat (20) begin
        seed = xs(seed);
        send(int'($signed(seed[13:0])), int'($signed(seed[29:16])));
      end
    end
    slow <= 0;
    skew = 0;
    apb(1, ADDR_SKEW, 0);
    apb(1, ADDR_METER, 32'hBB8);
    corr(1, 4'hF, 7'd100);
    corr(1, 4'hE, 7'd50);
    corr(-1, 4'hF, 7'd0);
    apb(1, ADDR_METER, 0);
    corr(1, 4'hF, 7'd0);
    print_verdict();
  end
endmodule

// file: src/swc_dly_if.sv
// port bundle between the datapath and its delay line memory
`timescale 1ns/1ps
interface swc_dly_if;
  import swc_pkg::*;
  logic              we;
  logic [DLY_AW-1:0] waddr;
  logic [DLY_AW-1:0] raddr;
  logic [2*SW-1:0]   wdata;
  logic [2*SW-1:0]   rdata;
  modport ctl (output we, waddr, raddr, wdata, input rdata);
  modport mem (input we, waddr, raddr, wdata, output rdata);
endinterface

// file: src/swc_dly_ram.sv
// sample delay line: one left/right pair per word, registered read
`timescale 1ns/1ps
module swc_dly_ram (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  swc_dly_if.mem   port_io
);
  import swc_pkg::*;
  logic [2*SW-1:0] mem_q [2**DLY_AW];
  logic [2*SW-1:0] rdata_q;

  // read before write, so a same-address access returns the old word
  always_ff @(posedge clk_i) begin
    if (ce_i && port_io.we) begin
      mem_q[port_io.waddr] <= port_io.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= '0;
    end else if (ce_i) begin
      rdata_q <= mem_q[port_io.raddr];
    end
  end

  assign port_io.rdata = rdata_q;
endmodule

// file: src/swc_pkg.sv
// shared constants, register map and state encoding of the stereo width block
package swc_pkg;
  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int SW     = 16;  // sample width at the ports
  localparam int IW     = 18;  // internal sample width, headroom for sums
  localparam int DLY_AW = 9;   // delay line address width
  localparam int MS_W   = 31;  // mean-square accumulator width

  // ****************************************************************
  // gain codes: half-dB steps, code 0 is -79.0 dB, 206 is +24.0 dB
  // ****************************************************************
  localparam logic [7:0] GAIN_OFF      = 8'hFF;
  localparam logic [7:0] GAIN_CODE_MAX = 8'hCE;
  localparam logic [7:0] GAIN_0DB      = 8'h9E;
  localparam logic [7:0] GAIN_BIAS     = 8'h0A;  // moves 0 dB onto an octave edge
  localparam logic [7:0] GAIN_STEPS    = 8'h0C;  // half-dB steps per octave
  localparam int         GAIN_SHIFT    = 29;
  localparam logic [15:0] MANT [12] = '{16'h8000, 16'h8796, 16'h8F9E, 16'h9822,
                                        16'hA124, 16'hAAB2, 16'hB4CF, 16'hBF85,
                                        16'hCADF, 16'hD6E4, 16'hE39F, 16'hF11C};

  // ****************************************************************
  // skew, shelf and meter limits
  // ****************************************************************
  localparam logic signed [9:0] SKEW_MAX   = 10'sh1F4;  // 500 samples
  localparam logic [14:0]       CORNER_MIN = 15'h0008;
  localparam logic [14:0]       CORNER_MAX = 15'h6200;  // 25088 Hz
  localparam logic [14:0]       CORNER_RST = 15'h00C8;
  localparam real               FS_HZ      = 48000.0;
  localparam int SHELF_K_SCALE = int'(6.2831853 * 32768.0 * 256.0 / FS_HZ);
  localparam int                SHELF_K_SHIFT = 8;
  localparam int                COEF_SHIFT    = 15;
  localparam logic [16:0]       K_ONE      = 17'h07FFF;
  localparam logic [11:0]       RATE_MAX   = 12'hBB8;   // 300.0 dB/s in 0.1 steps
  localparam logic [11:0]       RATE_RST   = 12'h3E8;
  localparam logic [4:0]        MS_SHIFT_TOP = 5'h10;
  localparam logic [6:0]        CORR_FULL  = 7'h64;     // 100 %
  localparam logic [2:0]        BIT_UPDATE = 3'h7;

  // ****************************************************************
  // register map and field positions
  // ****************************************************************
  localparam int          AW          = 12;
  localparam logic [11:0] ADDR_GAIN_IN  = 12'h000;
  localparam logic [11:0] ADDR_GAIN_MID = 12'h004;
  localparam logic [11:0] ADDR_SKEW     = 12'h008;
  localparam logic [11:0] ADDR_SHELF    = 12'h00C;
  localparam logic [11:0] ADDR_METER    = 12'h010;
  localparam logic [11:0] ADDR_STATUS   = 12'h014;
  localparam int F_LO = 0;
  localparam int F_HI = 8;
  localparam int F_CORNER = 16;
  localparam int F_BUSY = 8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_GAIN = 3'h1, ST_SUMDIF = 3'h3, ST_SCALE = 3'h2,
    ST_SHELF = 3'h6, ST_MIX = 3'h7, ST_METER = 3'h5, ST_OUT = 3'h4
  } swc_state_e;
endpackage

// file: src/swc_stereo_width.sv
// stereo width datapath with shelf on the side path and correlation meter
`timescale 1ns/1ps
module swc_stereo_width (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    ce_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [swc_pkg::AW-1:0]  paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic                         pready_o,
  output logic [31:0]                  prdata_o,
  output logic                         pslverr_o,
  input  wire logic                    s_valid_i,
  output logic                         s_ready_o,
  input  wire logic [swc_pkg::SW-1:0]  s_left_i,
  input  wire logic [swc_pkg::SW-1:0]  s_right_i,
  output logic                         m_valid_o,
  input  wire logic                    m_ready_i,
  output logic [swc_pkg::SW-1:0]       m_left_o,
  output logic [swc_pkg::SW-1:0]       m_right_o
);
  import swc_pkg::*;

  // ****************************************************************
  // arithmetic helpers
  // ****************************************************************
  function automatic logic signed [IW-1:0] sat_f(input logic signed [52:0] v);
    logic signed [52:0] hi;
    hi = 53'sd1 <<< (IW - 1);
    if (v >= hi) sat_f = {1'b0, {(IW-1){1'b1}}};
    else if (v < -hi) sat_f = {1'b1, {(IW-1){1'b0}}};
    else sat_f = v[IW-1:0];
  endfunction

  function automatic logic signed [SW-1:0] sat16_f(input logic signed [IW+1:0] v);
    logic signed [IW+1:0] hi;
    hi = (IW+2)'(1) <<< (SW - 1);
    if (v >= hi) sat16_f = {1'b0, {(SW-1){1'b1}}};
    else if (v < -hi) sat16_f = {1'b1, {(SW-1){1'b0}}};
    else sat16_f = v[SW-1:0];
  endfunction

  // half-dB code to linear: mantissa table times a power of two
  function automatic logic signed [IW-1:0] gain_f(input logic signed [IW-1:0] x,
                                                 input logic [7:0] code);
    logic [7:0]         c;
    logic [3:0]         fr;
    logic [4:0]         oc;
    logic signed [34:0] p;
    logic signed [52:0] w;
    c  = ((code > GAIN_CODE_MAX) ? GAIN_CODE_MAX : code) + GAIN_BIAS;
    fr = 4'(c % GAIN_STEPS);
    oc = 5'(c / GAIN_STEPS);
    p  = x * $signed({1'b0, MANT[fr]});
    w  = (53'(p) <<< oc) >>> GAIN_SHIFT;
    gain_f = (code == GAIN_OFF) ? '0 : sat_f(w);
  endfunction

  function automatic logic [4:0] msb_f(input logic [11:0] v);
    msb_f = 5'h00;
    for (int i = 0; i < 12; i++) begin
      if (v[i]) msb_f = 5'(i);
    end
  endfunction

  // ****************************************************************
  // registers seen by software
  // ****************************************************************
  logic [7:0]        r_gl_q, r_gr_q, r_gc_q, r_gs_q, r_shg_q;
  logic signed [9:0] r_skew_q;
  logic [14:0]       r_corner_q;
  logic [11:0]       r_rate_q;
  logic [6:0]        corr_q;
  logic              vld_q;  // read data loaded for the transfer in flight
  swc_state_e        st_q, st_d;

  wire apb_done  = psel_i && penable_i && vld_q;
  wire apb_wr    = apb_done && pwrite_i && ce_i;
  wire hit_in    = paddr_i == ADDR_GAIN_IN;
  wire hit_mid   = paddr_i == ADDR_GAIN_MID;
  wire hit_skew  = paddr_i == ADDR_SKEW;
  wire hit_shelf = paddr_i == ADDR_SHELF;
  wire hit_meter = paddr_i == ADDR_METER;
  wire hit_stat  = paddr_i == ADDR_STATUS;
  wire mapped    = hit_in | hit_mid | hit_skew | hit_shelf | hit_meter | hit_stat;
  wire [31:0] rd_mux = hit_in    ? {16'h0000, r_gr_q, r_gl_q} :
                       hit_mid   ? {16'h0000, r_gs_q, r_gc_q} :
                       hit_skew  ? {{22{r_skew_q[9]}}, r_skew_q} :
                       hit_shelf ? {1'b0, r_corner_q, 8'h00, r_shg_q} :
                       hit_meter ? {20'h00000, r_rate_q} :
                       hit_stat  ? {23'h000000, st_q != ST_IDLE, 1'b0, corr_q} :
                       32'h0000_0000;

  // answer once read data is loaded; a freeze in setup adds a wait state
  assign pready_o  = ce_i && vld_q;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // read data captured at the first enabled edge of the transfer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h0000_0000;
      vld_q    <= 1'b0;
    end else if (ce_i) begin
      if (psel_i && !apb_done) prdata_o <= rd_mux;
      vld_q <= psel_i && !apb_done;
    end
  end

  // software writes only change the staged set; the datapath copies it later
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_gl_q     <= GAIN_0DB;
      r_gr_q     <= GAIN_0DB;
      r_gc_q     <= GAIN_0DB;
      r_gs_q     <= GAIN_0DB;
      r_shg_q    <= GAIN_0DB;
      r_skew_q   <= 10'sh000;
      r_corner_q <= CORNER_RST;
      r_rate_q   <= RATE_RST;
    end else if (apb_wr) begin
      if (hit_in) {r_gr_q, r_gl_q} <= pwdata_i[F_HI+7:F_LO];
      if (hit_mid) {r_gs_q, r_gc_q} <= pwdata_i[F_HI+7:F_LO];
      if (hit_skew) r_skew_q <= pwdata_i[9:0];
      if (hit_shelf) r_shg_q <= pwdata_i[F_LO+7:F_LO];
      if (hit_shelf) r_corner_q <= pwdata_i[F_CORNER+14:F_CORNER];
      if (hit_meter) r_rate_q <= pwdata_i[11:0];
    end
  end

  // ****************************************************************
  // per-sample settings, clamped into their legal ranges
  // ****************************************************************
  wire signed [9:0] skew_c = (r_skew_q > SKEW_MAX) ? SKEW_MAX :
                             (r_skew_q < -SKEW_MAX) ? -SKEW_MAX : r_skew_q;
  wire [8:0]  mag_c    = skew_c[9] ? 9'(-skew_c) : 9'(skew_c);
  wire [14:0] corner_c = (r_corner_q < CORNER_MIN) ? CORNER_MIN :
                         (r_corner_q > CORNER_MAX) ? CORNER_MAX : r_corner_q;
  wire [25:0] k_raw    = (26'(corner_c) * 26'(SHELF_K_SCALE)) >> SHELF_K_SHIFT;
  wire [16:0] k_c      = (k_raw > 26'(K_ONE)) ? K_ONE : k_raw[16:0];
  wire [7:0]  shg_c    = (r_shg_q > GAIN_CODE_MAX) ? GAIN_CODE_MAX : r_shg_q;
  wire [11:0] rate_c   = (r_rate_q > RATE_MAX) ? RATE_MAX : r_rate_q;

  logic [7:0]        p_gl_q, p_gr_q, p_gc_q, p_gs_q, p_shg_q;
  logic signed [9:0] p_skew_q;
  logic [8:0]        p_mag_q;
  logic [16:0]       p_k_q;
  logic [11:0]       p_rate_q;
  wire accept = s_valid_i && s_ready_o;

  // one copy per sample, so both channels see the same set
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {p_gl_q, p_gr_q, p_gc_q, p_gs_q, p_shg_q} <= {5{GAIN_0DB}};
      {p_skew_q, p_mag_q, p_k_q, p_rate_q} <= '0;
    end else if (accept) begin
      {p_gl_q, p_gr_q, p_gc_q, p_gs_q} <= {r_gl_q, r_gr_q, r_gc_q, r_gs_q};
      {p_shg_q, p_skew_q, p_mag_q} <= {shg_c, skew_c, mag_c};
      {p_k_q, p_rate_q} <= {k_c, rate_c};
    end
  end

  // ****************************************************************
  // delay line
  // ****************************************************************
  swc_dly_if dly ();
  logic [DLY_AW-1:0] wp_q, fill_q;
  assign dly.we    = accept;
  assign dly.waddr = wp_q;
  assign dly.raddr = wp_q - mag_c;
  assign dly.wdata = {s_left_i, s_right_i};

  swc_dly_ram u_ram (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .ce_i    (ce_i),
    .port_io (dly)
  );

  // fill count keeps never-written words out of the path after reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_q   <= '0;
      fill_q <= '0;
    end else if (accept) begin
      wp_q   <= wp_q + 1'b1;
      fill_q <= (&fill_q) ? fill_q : fill_q + 1'b1;
    end
  end

  // ****************************************************************
  // datapath
  // ****************************************************************
  logic [SW-1:0]        x_l_q, x_r_q, out_l_q, out_r_q;
  logic signed [IW-1:0] a_l_q, a_r_q, sum_q, dif_q, lp_q;
  logic [MS_W-1:0]      ms_s_q, ms_p_q;
  logic [6:0]           res_q;
  logic [2:0]           bit_q;
  logic [1:0]           fc_q;  // output buffer fill count
  wire                  fb_full = fc_q[1];

  wire dly_ok = fill_q > p_mag_q;
  wire [SW-1:0] rd_l = dly_ok ? dly.rdata[2*SW-1:SW] : '0;
  wire [SW-1:0] rd_r = dly_ok ? dly.rdata[SW-1:0] : '0;
  wire [SW-1:0] l_src = (p_skew_q > 10'sh000) ? rd_l : x_l_q;
  wire [SW-1:0] r_src = (p_skew_q < 10'sh000) ? rd_r : x_r_q;
  wire signed [IW-1:0] gl_w = gain_f(IW'($signed(l_src)), p_gl_q);
  wire signed [IW-1:0] gr_w = gain_f(IW'($signed(r_src)), p_gr_q);
  wire signed [IW:0] sum_w = (IW+1)'(a_l_q) + (IW+1)'(a_r_q);
  wire signed [IW:0] dif_w = (IW+1)'(a_l_q) - (IW+1)'(a_r_q);
  wire signed [IW:0] lp_err = (IW+1)'(dif_q) - (IW+1)'(lp_q);
  wire signed [36:0] lp_step = lp_err * $signed({1'b0, p_k_q});
  wire signed [IW-1:0] lp_w = lp_q + IW'(lp_step >>> COEF_SHIFT);
  wire signed [IW:0] shelf_w = (IW+1)'(dif_q)
                             + (IW+1)'(gain_f(lp_q, p_shg_q)) - (IW+1)'(lp_q);
  wire signed [IW+1:0] mix_l = (IW+2)'(sum_q) + (IW+2)'(shelf_w);
  wire signed [IW+1:0] mix_r = (IW+2)'(sum_q) - (IW+2)'(shelf_w);

  // meter works on the outputs; the half sum keeps the square in range
  wire signed [SW:0]     hs_w = ((SW+1)'($signed(out_l_q)) + (SW+1)'($signed(out_r_q))) >>> 1;
  wire signed [2*SW+1:0] sq_s = hs_w * hs_w;
  wire signed [2*SW-1:0] sq_l = $signed(out_l_q) * $signed(out_l_q);
  wire signed [2*SW-1:0] sq_r = $signed(out_r_q) * $signed(out_r_q);
  wire [2*SW:0]          sq_p = ((2*SW+1)'(sq_l) + (2*SW+1)'(sq_r)) >> 1;
  wire [4:0]             ms_sh = MS_SHIFT_TOP - msb_f(p_rate_q);
  wire signed [MS_W+1:0] ds_w = (MS_W+2)'(sq_s) - (MS_W+2)'(ms_s_q);
  wire signed [MS_W+1:0] dp_w = (MS_W+2)'(sq_p) - (MS_W+2)'(ms_p_q);
  wire [MS_W-1:0] ms_s_w = ms_s_q + MS_W'(ds_w >>> ms_sh);
  wire [MS_W-1:0] ms_p_w = ms_p_q + MS_W'(dp_w >>> ms_sh);
  // percentage by a seven-step search, trial * p against 100 * s
  wire [6:0]  trial  = res_q | 7'(8'h01 << bit_q);
  wire [37:0] lhs    = 38'(trial) * 38'(ms_p_q);
  wire [37:0] rhs    = 38'(CORR_FULL) * 38'(ms_s_q);
  wire [6:0]  res_w  = (lhs <= rhs) ? trial : res_q;

  // fsm: one stage per state, the meter stage loops over the search bits
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:   if (accept) st_d = ST_GAIN;
      ST_GAIN:   st_d = ST_SUMDIF;
      ST_SUMDIF: st_d = ST_SCALE;
      ST_SCALE:  st_d = ST_SHELF;
      ST_SHELF:  st_d = ST_MIX;
      ST_MIX:    st_d = ST_METER;
      ST_METER:  if (bit_q == 3'h0) st_d = ST_OUT;
      ST_OUT:    if (!fb_full) st_d = ST_IDLE;
      default:   st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) st_q <= ST_IDLE;
    else if (ce_i) st_q <= st_d;
  end

  // sample stages
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {x_l_q, x_r_q, out_l_q, out_r_q} <= '0;
      {a_l_q, a_r_q, sum_q, dif_q, lp_q} <= '0;
    end else if (ce_i) begin
      if (accept) {x_l_q, x_r_q} <= {s_left_i, s_right_i};
      if (st_q == ST_GAIN) {a_l_q, a_r_q} <= {gl_w, gr_w};
      if (st_q == ST_SUMDIF) {sum_q, dif_q} <= {sum_w[IW:1], dif_w[IW:1]};
      if (st_q == ST_SCALE) sum_q <= gain_f(sum_q, p_gc_q);
      if (st_q == ST_SCALE) dif_q <= gain_f(dif_q, p_gs_q);
      if (st_q == ST_SHELF) lp_q <= lp_w;
      if (st_q == ST_MIX) {out_l_q, out_r_q} <= {sat16_f(mix_l), sat16_f(mix_r)};
    end
  end

  // meter: zero ballistics freezes the means
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {ms_s_q, ms_p_q} <= '0;
      {res_q, corr_q} <= '0;
      bit_q <= BIT_UPDATE;
    end else if (ce_i) begin
      if (st_q == ST_MIX) bit_q <= BIT_UPDATE;
      if (st_q == ST_METER && bit_q == BIT_UPDATE) begin
        if (p_rate_q != 12'h000) {ms_s_q, ms_p_q} <= {ms_s_w, ms_p_w};
        res_q <= 7'h00;
        bit_q <= 3'h6;
      end else if (st_q == ST_METER) begin
        res_q <= res_w;
        bit_q <= bit_q - 3'h1;
        if (bit_q == 3'h0) corr_q <= (res_w > CORR_FULL) ? CORR_FULL : res_w;
      end
    end
  end

  // ****************************************************************
  // two-entry output buffer; a full buffer holds the fsm in ST_OUT
  // ****************************************************************
  logic [2*SW-1:0] fb_q [2];
  logic            fw_q, fr_q;
  wire push    = ce_i && st_q == ST_OUT && !fb_full;
  wire pop     = ce_i && m_valid_o && m_ready_i;

  for (genvar i = 0; i < 2; i++) begin : g_buf
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) fb_q[i] <= '0;
      else if (push && fw_q == 1'(i)) fb_q[i] <= {out_l_q, out_r_q};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {fw_q, fr_q, fc_q} <= '0;
    end else begin
      if (push) fw_q <= !fw_q;
      if (pop) fr_q <= !fr_q;
      fc_q <= fc_q + 2'(push) - 2'(pop);
    end
  end

  assign s_ready_o = ce_i && st_q == ST_IDLE;
  assign m_valid_o = fc_q != 2'h0;
  assign {m_left_o, m_right_o} = fb_q[fr_q];

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i || !ce_i);

  property p_sum_half;
    (st_q == ST_SUMDIF) |=> sum_q == $past(sum_w[IW:1]) && dif_q == $past(dif_w[IW:1]);
  endproperty
  a_sum_half: assert property (p_sum_half) else $error("sum or difference wrong");
  property p_mix;
    (st_q == ST_MIX) |=> out_l_q == $past(sat16_f(mix_l)) && out_r_q == $past(sat16_f(mix_r));
  endproperty
  a_mix: assert property (p_mix) else $error("recombination wrong");
  property p_off_zero;
    (st_q == ST_GAIN && p_gl_q == GAIN_OFF) |=> a_l_q == '0;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("off gain not zero");
  property p_skew_src;
    (st_q == ST_GAIN && p_skew_q < 10'sh000) |-> l_src == x_l_q && r_src == rd_r;
  endproperty
  a_skew_src: assert property (p_skew_src) else $error("wrong channel delayed");
  property p_params_hold;
    (st_q != ST_IDLE) |=> $stable(p_gl_q) && $stable(p_gr_q) && $stable(p_skew_q);
  endproperty
  a_params_hold: assert property (p_params_hold) else $error("settings moved");
  property p_corr_max;
    corr_q <= CORR_FULL;
  endproperty
  a_corr_max: assert property (p_corr_max) else $error("correlation over 100");
  property p_frozen;
    (st_q == ST_METER && bit_q == BIT_UPDATE && p_rate_q == 12'h000) |=> $stable(ms_s_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("meter moved at zero rate");
  property p_latency;
    accept |-> ##[14:14] st_q == ST_OUT;
  endproperty
  a_latency: assert property (p_latency) else $error("sample latency wrong");
  property p_hold_out;
    (m_valid_o && !m_ready_i) |=> m_valid_o && $stable(m_left_o) && $stable(m_right_o);
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("output dropped under stall");

  c_full: cover property (fb_full && st_q == ST_OUT);
  c_skew_l: cover property (st_q == ST_GAIN && p_skew_q > 10'sh000 && dly_ok);
  c_mono: cover property (st_q == ST_OUT && corr_q == CORR_FULL);
endmodule
